/* verilog/fio_image_cfg.svh */
// Purpose: offsets, field positions, reset values and timing counts of the io image
// Assumes: 32-bit AXI4-Lite data, 8-bit byte addresses
// Notes: definitions only
`ifndef FIO_IMAGE_CFG_SVH
`define FIO_IMAGE_CFG_SVH

`define FIO_AXI_AW 8
`define FIO_OFS_STATUS_WORD 8'h00
`define FIO_OFS_IN_IMAGE 8'h04
`define FIO_OFS_OUT_IMAGE 8'h08
`define FIO_OFS_FS_BEHAV 8'h0C
`define FIO_OFS_FS_PATTERN 8'h10
`define FIO_OFS_DIAG_STORE 8'h14
`define FIO_OFS_IRQ_STATUS 8'h18
`define FIO_OFS_IRQ_MASK 8'h1C
`define FIO_OFS_CTRL 8'h20
`define FIO_OFS_SYS_STATE 8'h24
`define FIO_OFS_PD_SEL 8'h28
`define FIO_OFS_PD_DATA 8'h2C
`define FIO_OFS_PD_LEN 8'h30

`define FIO_RESP_OKAY 2'h0
`define FIO_RESP_SLVERR 2'h2

`define FIO_FS_CLEAR 2'h0
`define FIO_FS_SET 2'h1
`define FIO_FS_HOLD 2'h2
`define FIO_FS_SUBST 2'h3
`define FIO_FS_BEHAV_RST 2'h0
`define FIO_FS_PATTERN_RST 16'h0000
`define FIO_CTRL_RST 1'h1

`define FIO_SLOT_IM 4'h0
`define FIO_SLOT_STATUS 4'h1
`define FIO_SLOT_IO 4'h2
`define FIO_STATUS_BYTES 8'h04
`define FIO_IO_IN_BYTES 8'h01
`define FIO_IM_LAST 4'h4
`define FIO_IM_EMPTY 32'h20202020
`define FIO_IM_VERSION 16'h0101

`define FIO_DIAG_N 7
`define FIO_GROUP_SIZE 4
`define FIO_DT_OVERTEMP 4'h1
`define FIO_DT_US_SURGE 4'h2
`define FIO_DT_US_OVERLOAD 4'h3
`define FIO_DT_UA_SURGE 4'h4
`define FIO_DT_UA_UNDER 4'h5
`define FIO_DT_OUT_FAULT 4'h6

`define FIO_IRQ_N 4
`define FIO_IRQ_ALARM_IN 0
`define FIO_IRQ_ALARM_OUT 1
`define FIO_IRQ_FS_ENTER 2
`define FIO_IRQ_OPERATIONAL 3

`define FIO_CLK_MHZ 200
`define FIO_QUICK_BOOT_MS 500
`define FIO_NORMAL_BOOT_MS 1000
`define FIO_BOOT_CW 28

`endif

/* verilog/fio_image_pkg.sv */
// Purpose: types shared by the io image design
// Assumes: nothing beyond the cfg header
// Notes: types only
package fio_image_pkg;
  typedef enum logic [1:0] {OWN_NONE, OWN_A, OWN_B} fio_owner_t;
endpackage : fio_image_pkg

/* verilog/fio_sync.sv */
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are quasi-static levels
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module fio_sync #(
  parameter int W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : fio_sync

/* verilog/fio_image.sv */
// Purpose: process-data image, failsafe outputs and diagnostics of a fieldbus io device
// Assumes: controller-side signals are on aclk; fault and input pins are asynchronous
// Notes: registers over AXI4-Lite
// Function
// - slot 1 status: four input bytes; slot 2 io
// - status word bits 0-5 refreshed every cycle
// - input n+1 packed into in bit n
// - out bit n drives output n+1
// - failsafe: clear, set, hold or pattern
// - pattern 0..65535, used only in pattern mode
// - store entry, incoming alarm on new entry
// - outgoing alarm when an entry clears
// - station fault lit while any entry stored
// - diagnostics for supply, temperature, output faults
// - channel diagnostics reported per four channels
// - two readers; one writer: first connected once operational, A if both are connected
// - quick boot: operational within 500 ms
// - records 0-4 readable through slot 0
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "fio_image_cfg.svh"
module fio_image
  import fio_image_pkg::*;
#(
  parameter int unsigned QUICK_BOOT_CYCLES = `FIO_QUICK_BOOT_MS * `FIO_CLK_MHZ * 1000 - 1,
  parameter int unsigned NORMAL_BOOT_CYCLES = `FIO_NORMAL_BOOT_MS * `FIO_CLK_MHZ * 1000,
  parameter logic [15:0] IM_MAKER_ID = 16'h0000 // arbitrary value
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`FIO_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`FIO_AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] digital_input_channel,
  input wire logic [7:0] out_short_pin,
  input wire logic [7:0] out_overload_pin,
  input wire logic ua_short_pin,
  input wire logic ua_under_pin,
  input wire logic ua_surge_pin,
  input wire logic el_overload_pin,
  input wire logic el_under_pin,
  input wire logic us_surge_pin,
  input wire logic us_overload_pin,
  input wire logic overtemp_pin,
  input wire logic ctrl_a_conn,
  input wire logic ctrl_b_conn,
  input wire logic ctrl_a_out_valid,
  input wire logic [7:0] ctrl_a_out_data,
  input wire logic ctrl_b_out_valid,
  input wire logic [7:0] ctrl_b_out_data,
  output logic [7:0] digital_output,
  output logic station_fault_indicator,
  output logic alarm_valid,
  output logic alarm_incoming,
  output logic [3:0] alarm_type,
  output logic [3:0] alarm_slot,
  output logic [1:0] alarm_group,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] din_s, osc_s, oov_s, sup_s;

  fio_sync #(.W(32)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({digital_input_channel, out_short_pin, out_overload_pin, ua_short_pin, ua_under_pin,
        ua_surge_pin, el_overload_pin, el_under_pin, us_surge_pin, us_overload_pin, overtemp_pin}),
    .q({din_s, osc_s, oov_s, sup_s})
  );

  logic [31:0] status_word_q;
  logic [7:0] in_image_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_word_q <= 32'h0000_0000;
      in_image_q <= 8'h00;
    end else begin
      status_word_q <= {26'h0, sup_s[3], sup_s[4], sup_s[6], sup_s[7], |oov_s, |osc_s};
      in_image_q <= din_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file and bus slave
  logic awready_q, wready_q, aw_full_q, w_full_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q, wdata_q, rd_data;
  logic [3:0] wstrb_q;
  logic [`FIO_AXI_AW-1:0] awaddr_q;
  logic [1:0] fs_behav_q;
  logic [15:0] fs_pattern_q;
  logic [`FIO_IRQ_N-1:0] irq_stat_q, irq_mask_q, irq_ev;
  logic quick_boot_feature_q;
  logic [7:0] pd_sel_q;
  logic rd_ok;
  logic do_write;
  logic [31:0] wmask;

  assign do_write = aw_full_q && w_full_q && !bvalid_q;
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        awready_q <= 1'b0;
        aw_full_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_full_q <= 1'b0;
      end else if (!aw_full_q && !bvalid_q) begin
        awready_q <= 1'b1;
      end
      if (s_axi_wvalid && wready_q) begin
        wready_q <= 1'b0;
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_full_q <= 1'b0;
      end else if (!w_full_q && !bvalid_q) begin
        wready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= `FIO_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      case (awaddr_q)
        `FIO_OFS_FS_BEHAV, `FIO_OFS_FS_PATTERN, `FIO_OFS_IRQ_STATUS, `FIO_OFS_IRQ_MASK,
        `FIO_OFS_CTRL, `FIO_OFS_PD_SEL: bresp_q <= `FIO_RESP_OKAY;
        `FIO_OFS_STATUS_WORD, `FIO_OFS_IN_IMAGE, `FIO_OFS_OUT_IMAGE, `FIO_OFS_DIAG_STORE,
        `FIO_OFS_SYS_STATE, `FIO_OFS_PD_DATA, `FIO_OFS_PD_LEN: bresp_q <= `FIO_RESP_OKAY;
        default: bresp_q <= `FIO_RESP_SLVERR;
      endcase
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // software-writable configuration; read-only offsets silently ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fs_behav_q <= `FIO_FS_BEHAV_RST;
      fs_pattern_q <= `FIO_FS_PATTERN_RST;
      irq_mask_q <= '0;
      quick_boot_feature_q <= `FIO_CTRL_RST;
      pd_sel_q <= 8'h00;
    end else if (do_write) begin
      case (awaddr_q)
        `FIO_OFS_FS_BEHAV: fs_behav_q <= (wdata_q[1:0] & wmask[1:0]) | (fs_behav_q & ~wmask[1:0]);
        `FIO_OFS_FS_PATTERN: fs_pattern_q <= (wdata_q[15:0] & wmask[15:0]) | (fs_pattern_q & ~wmask[15:0]);
        `FIO_OFS_IRQ_MASK: irq_mask_q <= (wdata_q[`FIO_IRQ_N-1:0] & wmask[`FIO_IRQ_N-1:0])
                                         | (irq_mask_q & ~wmask[`FIO_IRQ_N-1:0]);
        `FIO_OFS_CTRL: quick_boot_feature_q <= wmask[0] ? wdata_q[0] : quick_boot_feature_q;
        `FIO_OFS_PD_SEL: pd_sel_q <= (wdata_q[7:0] & wmask[7:0]) | (pd_sel_q & ~wmask[7:0]);
        default: ;
      endcase
    end
  end

  // sticky events, write one to clear; a new event wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= '0;
      irq <= 1'b0;
    end else begin
      if (do_write && awaddr_q == `FIO_OFS_IRQ_STATUS) begin
        irq_stat_q <= (irq_stat_q & ~(wdata_q[`FIO_IRQ_N-1:0] & wmask[`FIO_IRQ_N-1:0])) | irq_ev;
      end else begin
        irq_stat_q <= irq_stat_q | irq_ev;
      end
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // connection ownership, failsafe and boot
  fio_owner_t owner_q;
  logic failsafe_q, operational_q, op_prev_q, fs_prev_q;
  logic [`FIO_BOOT_CW-1:0] boot_cnt_q, boot_limit;
  logic [7:0] out_q;
  logic owner_lost, owner_valid;
  logic [7:0] owner_data;

  assign boot_limit = quick_boot_feature_q ? `FIO_BOOT_CW'(QUICK_BOOT_CYCLES) : `FIO_BOOT_CW'(NORMAL_BOOT_CYCLES);
  assign owner_lost = (owner_q == OWN_A && !ctrl_a_conn) || (owner_q == OWN_B && !ctrl_b_conn);
  assign owner_valid = (owner_q == OWN_A && ctrl_a_out_valid) || (owner_q == OWN_B && ctrl_b_out_valid);
  assign owner_data = (owner_q == OWN_B) ? ctrl_b_out_data : ctrl_a_out_data;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_cnt_q <= '0;
      operational_q <= 1'b0;
    end else if (!operational_q) begin
      if (boot_cnt_q >= boot_limit) begin
        operational_q <= 1'b1;
      end else begin
        boot_cnt_q <= boot_cnt_q + 1'b1;
      end
    end
  end

  // both controllers may read; once operational the first connected owns the outputs, A if both are connected
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      owner_q <= OWN_NONE;
    end else begin
      case (owner_q)
        OWN_NONE: begin
          if (operational_q && ctrl_a_conn) begin
            owner_q <= OWN_A;
          end else if (operational_q && ctrl_b_conn) begin
            owner_q <= OWN_B;
          end
        end
        OWN_A, OWN_B: begin
          if (owner_lost) begin
            owner_q <= OWN_NONE;
          end
        end
        default: owner_q <= OWN_NONE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      failsafe_q <= 1'b1;
    end else if (owner_q == OWN_NONE || owner_lost) begin
      failsafe_q <= 1'b1;
    end else if (owner_valid) begin
      failsafe_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_q <= 8'h00;
    end else if (owner_valid && !owner_lost) begin
      out_q <= owner_data;
    end else if (failsafe_q) begin
      case (fs_behav_q)
        `FIO_FS_CLEAR: out_q <= 8'h00;
        `FIO_FS_SET: out_q <= 8'hFF;
        `FIO_FS_HOLD: out_q <= out_q;
        `FIO_FS_SUBST: out_q <= fs_pattern_q[7:0];
        default: out_q <= 8'h00;
      endcase
    end
  end

  assign digital_output = out_q;

  ////////////////////////////////////////////////////////////////////////////
  // diagnostic store; one alarm per cycle, lowest index first
  logic [`FIO_DIAG_N-1:0] diag_now, diag_q, diag_diff;
  logic [2:0] pick;
  logic found;

  always_comb begin
    diag_now = {|(osc_s[7:4] | oov_s[7:4]), |(osc_s[3:0] | oov_s[3:0]),
                sup_s[6], sup_s[5], sup_s[1], sup_s[2], sup_s[0]};
    diag_diff = diag_now ^ diag_q;
    pick = 3'h0;
    found = 1'b0;
    for (int i = 0; i < `FIO_DIAG_N; i++) begin
      if (diag_diff[i] && !found) begin
        pick = 3'(i);
        found = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      diag_q <= '0;
      alarm_valid <= 1'b0;
      alarm_incoming <= 1'b0;
      alarm_type <= 4'h0;
      alarm_slot <= 4'h0;
      alarm_group <= 2'h0;
      station_fault_indicator <= 1'b0;
    end else begin
      alarm_valid <= found;
      station_fault_indicator <= |diag_q;
      if (found) begin
        diag_q[pick] <= diag_now[pick];
        alarm_incoming <= diag_now[pick];
        alarm_slot <= (pick >= 3'h5) ? `FIO_SLOT_IO : `FIO_SLOT_IM;
        alarm_group <= (pick == 3'h6) ? 2'h1 : 2'h0;
        case (pick)
          3'h0: alarm_type <= `FIO_DT_OVERTEMP;
          3'h1: alarm_type <= `FIO_DT_US_SURGE;
          3'h2: alarm_type <= `FIO_DT_US_OVERLOAD;
          3'h3: alarm_type <= `FIO_DT_UA_SURGE;
          3'h4: alarm_type <= `FIO_DT_UA_UNDER;
          default: alarm_type <= `FIO_DT_OUT_FAULT;
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_prev_q <= 1'b0;
      fs_prev_q <= 1'b1;
    end else begin
      op_prev_q <= operational_q;
      fs_prev_q <= failsafe_q;
    end
  end

  always_comb begin
    irq_ev = '0;
    irq_ev[`FIO_IRQ_ALARM_IN] = alarm_valid && alarm_incoming;
    irq_ev[`FIO_IRQ_ALARM_OUT] = alarm_valid && !alarm_incoming;
    irq_ev[`FIO_IRQ_FS_ENTER] = failsafe_q && !fs_prev_q;
    irq_ev[`FIO_IRQ_OPERATIONAL] = operational_q && !op_prev_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read side; the slot window serves status, io image and records
  always_comb begin
    rd_ok = 1'b1;
    rd_data = 32'h0000_0000;
    case (s_axi_araddr)
      `FIO_OFS_STATUS_WORD: rd_data = status_word_q;
      `FIO_OFS_IN_IMAGE: rd_data = {24'h0, in_image_q};
      `FIO_OFS_OUT_IMAGE: rd_data = {24'h0, out_q};
      `FIO_OFS_FS_BEHAV: rd_data = {30'h0, fs_behav_q};
      `FIO_OFS_FS_PATTERN: rd_data = {16'h0, fs_pattern_q};
      `FIO_OFS_DIAG_STORE: rd_data = {25'h0, diag_q};
      `FIO_OFS_IRQ_STATUS: rd_data = {28'h0, irq_stat_q};
      `FIO_OFS_IRQ_MASK: rd_data = {28'h0, irq_mask_q};
      `FIO_OFS_CTRL: rd_data = {31'h0, quick_boot_feature_q};
      `FIO_OFS_SYS_STATE: rd_data = {26'h0, owner_q, ctrl_b_conn, ctrl_a_conn, failsafe_q, operational_q};
      `FIO_OFS_PD_SEL: rd_data = {24'h0, pd_sel_q};
      `FIO_OFS_PD_DATA: begin
        case (pd_sel_q[3:0])
          `FIO_SLOT_STATUS: rd_data = status_word_q;
          `FIO_SLOT_IO: rd_data = {24'h0, in_image_q};
          `FIO_SLOT_IM: begin
            if (pd_sel_q[7:4] == 4'h0) begin
              rd_data = {IM_MAKER_ID, `FIO_IM_VERSION};
            end else if (pd_sel_q[7:4] <= `FIO_IM_LAST) begin
              rd_data = `FIO_IM_EMPTY;
            end
          end
          default: rd_data = 32'h0000_0000;
        endcase
      end
      `FIO_OFS_PD_LEN: begin
        case (pd_sel_q[3:0])
          `FIO_SLOT_STATUS: rd_data = {24'h0, `FIO_STATUS_BYTES};
          `FIO_SLOT_IO: rd_data = {24'h0, `FIO_IO_IN_BYTES};
          default: rd_data = 32'h0000_0000;
        endcase
      end
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `FIO_RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_data;
      rresp_q <= rd_ok ? `FIO_RESP_OKAY : `FIO_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_status_rsvd;
    status_word_q[31:6] == 26'h0 && (status_word_q[0] == $past(|osc_s));
  endproperty
  a_status_rsvd: assert property (p_status_rsvd) else $error("status word wrong");

  property p_in_pack;
    $past(aresetn, 3) |-> in_image_q == $past(digital_input_channel, 3);
  endproperty
  a_in_pack: assert property (p_in_pack) else $error("input byte wrong");

  property p_fs_clear;
    failsafe_q && !owner_valid && fs_behav_q == `FIO_FS_CLEAR |=> digital_output == 8'h00;
  endproperty
  a_fs_clear: assert property (p_fs_clear) else $error("failsafe clear failed");

  property p_fs_set;
    failsafe_q && !owner_valid && fs_behav_q == `FIO_FS_SET |=> digital_output == 8'hFF;
  endproperty
  a_fs_set: assert property (p_fs_set) else $error("failsafe set failed");

  property p_fs_hold;
    failsafe_q && !owner_valid && fs_behav_q == `FIO_FS_HOLD |=> $stable(digital_output);
  endproperty
  a_fs_hold: assert property (p_fs_hold) else $error("failsafe hold failed");

  property p_fs_subst;
    failsafe_q && !owner_valid && fs_behav_q == `FIO_FS_SUBST |=> digital_output == $past(fs_pattern_q[7:0]);
  endproperty
  a_fs_subst: assert property (p_fs_subst) else $error("substitute pattern not applied");

  property p_owner_loss;
    owner_q != OWN_NONE && owner_lost |=> failsafe_q && owner_q == OWN_NONE;
  endproperty
  a_owner_loss: assert property (p_owner_loss) else $error("owner loss missed");

  property p_second_ignored;
    owner_q == OWN_A && !ctrl_a_out_valid && !failsafe_q && !owner_lost |=> $stable(digital_output);
  endproperty
  a_second_ignored: assert property (p_second_ignored) else $error("non-owner wrote outputs");

  property p_alarm_in;
    alarm_valid && alarm_incoming |-> diag_q != '0 ##1 station_fault_indicator;
  endproperty
  a_alarm_in: assert property (p_alarm_in) else $error("incoming alarm without entry");

  property p_sf;
    station_fault_indicator == $past(|diag_q);
  endproperty
  a_sf: assert property (p_sf) else $error("station fault mismatch");

  property p_boot;
    $rose(operational_q) |-> $past(boot_cnt_q) >= $past(boot_limit);
  endproperty
  a_boot: assert property (p_boot) else $error("operational too early");

  c_fs_enter: cover property ($rose(failsafe_q));
  c_alarm_in: cover property (alarm_valid && alarm_incoming);
  c_alarm_out: cover property (alarm_valid && !alarm_incoming);
  c_owner_b: cover property (owner_q == OWN_B && owner_valid);

endmodule : fio_image

/* verification/fio_ctrl_model.sv */
// Purpose: cyclic controller stand-in driving one output byte stream
// Assumes: one aclk domain, requests change just after a rising edge
// Notes: data line shows the inverse once valid drops
`timescale 1ns/1ps
module fio_ctrl_model (
  input wire logic aclk,
  output logic conn,
  output logic out_valid,
  output logic [7:0] out_data
);
  initial begin
    conn = 1'h0;
    out_valid = 1'h0;
    out_data = 8'h00;
  end
  task automatic link(input logic up);
    @(posedge aclk);
    conn <= up;
  endtask : link
  task automatic send(input logic [7:0] b);
    @(posedge aclk);
    out_valid <= 1'h1;
    out_data <= b;
    @(posedge aclk);
    out_valid <= 1'h0;
    // stale byte would hide a late sampling slip
    out_data <= ~b;
  endtask : send
endmodule : fio_ctrl_model

/* verification/test_fio_image.sv */
// Purpose: self-checking bench for the io image
// Assumes: short boot counts, AXI4-Lite master tasks
// Notes: every fault pin driven; one write uses a partial strobe
`timescale 1ns/1ps
module test_fio_image;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, ua_sh, ua_un, el_un, ot, sf, av, ainc, irq;
  logic cac, cbc, cav, cbv, ua_sg, el_ov, us_sg, us_ov;
  logic [7:0] awaddr, araddr, din, osh, oov, dout, cad, cbd;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, atype, aslot;
  logic [1:0] bresp, rresp, agrp, g;
  int n_mismatch, samples_checked;
  always #2.5 aclk = ~aclk;
  fio_image #(.QUICK_BOOT_CYCLES(20), .NORMAL_BOOT_CYCLES(40)) fio_image_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .digital_input_channel(din),
    .out_short_pin(osh), .out_overload_pin(oov), .ua_short_pin(ua_sh), .ua_under_pin(ua_un),
    .ua_surge_pin(ua_sg), .el_overload_pin(el_ov), .el_under_pin(el_un), .us_surge_pin(us_sg),
    .us_overload_pin(us_ov), .overtemp_pin(ot), .ctrl_a_conn(cac), .ctrl_b_conn(cbc),
    .ctrl_a_out_valid(cav), .ctrl_a_out_data(cad), .ctrl_b_out_valid(cbv), .ctrl_b_out_data(cbd),
    .digital_output(dout), .station_fault_indicator(sf), .alarm_valid(av), .alarm_incoming(ainc),
    .alarm_type(atype), .alarm_slot(aslot), .alarm_group(agrp), .irq(irq));
  fio_ctrl_model ctrl_a_i (.aclk(aclk), .conn(cac), .out_valid(cav), .out_data(cad));
  fio_ctrl_model ctrl_b_i (.aclk(aclk), .conn(cbc), .out_valid(cbv), .out_data(cbd));
  ////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task automatic tmo;
    n_mismatch++;
    $display("wait limit reached at %0t", $time);
    summarize();
  endtask : tmo
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw = 1'h1;
    logic w = 1'h1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (aw && awready) begin
        awvalid <= 1'h0;
        aw = 1'h0;
      end
      if (w && wready) begin
        wvalid <= 1'h0;
        w = 1'h0;
      end
      if (bvalid) begin
        bready <= 1'h0;
        chk({30'h0, bresp}, {30'h0, er});
        return;
      end
    end
    tmo();
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) begin
        rready <= 1'h0;
        chk({30'h0, rresp}, {30'h0, er});
        // data of a refused read carries no meaning
        if (er == 2'h0) chk(rdata, exp);
        return;
      end
    end
    tmo();
  endtask : axr
  task automatic alm(input logic [8:0] exp);
    for (int n = 0; n < 32; n++) begin
      @(posedge aclk);
      if (av === 1'h1) begin
        g = agrp;
        chk({23'h0, ainc, atype, aslot}, {23'h0, exp});
        return;
      end
    end
    tmo();
  endtask : alm
  ////////////////////////////////////////////////////////////////
  task automatic t_boot;
    axr(8'h24, 32'h2, 2'h0);
    axr(8'h0C, 32'h0, 2'h0);
    axr(8'h10, 32'h0, 2'h0);
    axr(8'h20, 32'h1, 2'h0);
    // read before the normal count could end, so only quick boot passes
    repeat (12) @(posedge aclk);
    axr(8'h24, 32'h3, 2'h0);
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    axw(8'h20, 32'h0, 2'h0);
    axr(8'h20, 32'h0, 2'h0);
    repeat (20) @(posedge aclk);
    axr(8'h24, 32'h2, 2'h0);
    repeat (20) @(posedge aclk);
    axr(8'h24, 32'h3, 2'h0);
    wstrb <= 4'h2;
    axw(8'h10, 32'hFFFF12FF, 2'h0);
    wstrb <= 4'hF;
    axr(8'h10, 32'h1200, 2'h0);
    $display("t_boot done");
  endtask : t_boot
  task automatic t_status;
    @(posedge aclk);
    din <= 8'hA5;
    osh <= 8'h01;
    oov <= 8'h80;
    ua_sh <= 1'h1;
    ua_un <= 1'h1;
    el_ov <= 1'h1;
    el_un <= 1'h1;
    repeat (4) @(posedge aclk);
    axr(8'h04, 32'hA5, 2'h0);
    axr(8'h00, 32'h3F, 2'h0);
    axw(8'h28, 32'h1, 2'h0);
    axr(8'h30, 32'h4, 2'h0);
    axr(8'h2C, 32'h3F, 2'h0);
    axw(8'h28, 32'h2, 2'h0);
    axr(8'h2C, 32'hA5, 2'h0);
    axw(8'h28, 32'h40, 2'h0);
    axr(8'h2C, 32'h20202020, 2'h0);
    osh <= 8'h00;
    oov <= 8'h00;
    ua_sh <= 1'h0;
    ua_un <= 1'h0;
    el_ov <= 1'h0;
    el_un <= 1'h0;
    repeat (20) @(posedge aclk);
    $display("t_status done");
  endtask : t_status
  task automatic t_fs;
    logic [7:0] exp [4] = '{8'h00, 8'hFF, 8'h3C, 8'h96};
    for (int i = 0; i < 4; i++) begin
      axw(8'h0C, 32'(i), 2'h0);
      axw(8'h10, 32'hA596, 2'h0);
      ctrl_a_i.link(1'h1);
      repeat (2) @(posedge aclk);
      ctrl_a_i.send(8'h3C);
      repeat (2) @(posedge aclk);
      chk({24'h0, dout}, 32'h3C);
      ctrl_a_i.link(1'h0);
      repeat (4) @(posedge aclk);
      chk({24'h0, dout}, {24'h0, exp[i]});
    end
    $display("t_fs done");
  endtask : t_fs
  task automatic t_shared;
    ctrl_a_i.link(1'h1);
    ctrl_b_i.link(1'h1);
    repeat (2) @(posedge aclk);
    ctrl_a_i.send(8'h11);
    ctrl_b_i.send(8'hEE);
    repeat (2) @(posedge aclk);
    chk({24'h0, dout}, 32'h11);
    axr(8'h24, 32'h1D, 2'h0);
    ctrl_a_i.link(1'h0);
    repeat (3) @(posedge aclk);
    ctrl_b_i.send(8'h42);
    repeat (2) @(posedge aclk);
    chk({24'h0, dout}, 32'h42);
    ctrl_b_i.link(1'h0);
    $display("t_shared done");
  endtask : t_shared
  task automatic t_diag;
    axw(8'h18, 32'hF, 2'h0);
    axw(8'h1C, 32'h1, 2'h0);
    @(posedge aclk);
    ot <= 1'h1;
    alm({1'h1, 4'h1, 4'h0});
    repeat (3) @(posedge aclk);
    chk({31'h0, sf}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    axr(8'h18, 32'h1, 2'h0);
    axw(8'h18, 32'h1, 2'h0);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    ot <= 1'h0;
    alm({1'h0, 4'h1, 4'h0});
    repeat (3) @(posedge aclk);
    chk({31'h0, sf}, 32'h0);
    us_sg <= 1'h1;
    us_ov <= 1'h1;
    ua_sg <= 1'h1;
    alm({1'h1, 4'h2, 4'h0});
    alm({1'h1, 4'h3, 4'h0});
    alm({1'h1, 4'h4, 4'h0});
    us_sg <= 1'h0;
    us_ov <= 1'h0;
    ua_sg <= 1'h0;
    alm({1'h0, 4'h2, 4'h0});
    alm({1'h0, 4'h3, 4'h0});
    alm({1'h0, 4'h4, 4'h0});
    oov <= 8'h40;
    alm({1'h1, 4'h6, 4'h2});
    chk({30'h0, g}, 32'h1);
    oov <= 8'h00;
    alm({1'h0, 4'h6, 4'h2});
    axr(8'h40, 32'h0, 2'h2);
    axw(8'h44, 32'h0, 2'h2);
    $display("t_diag done");
  endtask : t_diag
  ////////////////////////////////////////////////////////////////
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ua_sh, ua_un, el_un, ot} = 11'h0;
    {ua_sg, el_ov, us_sg, us_ov} = 4'h0;
    {awaddr, araddr, din, osh, oov, wdata} = 72'h0;
    wstrb = 4'hF;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    t_boot();
    t_status();
    t_fs();
    t_shared();
    t_diag();
    summarize();
  end
endmodule : test_fio_image
